// File: hw/cia_alu_ops_decode.sv
// Decode and execute of the compressed shift, add/subtract, immediate and ALU formats.
//
// Functional notes
// - Shifted-move opcode 00 shifts source left by immediate.
// - Opcode 01 shifts source right logically, zero fill.
// - Opcode 10 shifts source right arithmetically, sign fill.
// - Every instruction here updates the condition flags.
// - Shifted-move reads and writes low registers only.
// - Three-operand add: source plus second register.
// - Three-operand add: source plus 3-bit immediate.
// - Three-operand subtract: source minus second register.
// - Three-operand subtract: source minus 3-bit immediate.
// - Immediate opcode 00 loads zero-extended byte.
// - Immediate compare sets flags, register unchanged.
// - Immediate opcode 10 adds byte into destination.
// - Immediate opcode 11 subtracts byte from destination.
// - AND, XOR, OR, AND-NOT, and invert copy.
// - Register-amount left, right, arithmetic shifts and rotate.
// - Add with carry, subtract with borrow.
// - Test, compare, compare negative set flags only.
// - Two's complement writes zero minus source.
// - Product of source and destination into destination.
// - Cycle count equals the native equivalent.
// - Only general registers 0 to 7 reachable.
`default_nettype none
module cia_alu_ops_decode #(
  parameter int DW   = 32,
  parameter int NREG = 8
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    instr_valid,
  input  wire logic [15:0]             instr,
  input  wire logic [$clog2(NREG)-1:0] peek_idx,
  output logic                         busy,
  output logic                         done,
  output logic                         not_ours,
  output logic                         wr_en,
  output logic      [$clog2(NREG)-1:0] wr_idx,
  output logic      [DW-1:0]           wr_data,
  output logic                         flag_n,
  output logic                         flag_z,
  output logic                         flag_c,
  output logic                         flag_v,
  output logic      [DW-1:0]           peek_data
);
  localparam int IW = $clog2(NREG);

  cia_pkg::cia_state_type state;
  logic [cia_pkg::CNT_W-1:0] cnt;
  logic [15:0]               held;
  logic [DW-1:0]             regs [NREG];

  logic [15:0]       cur;
  logic              accept;
  logic              is_f1;
  logic              is_f2;
  logic              is_f3;
  logic              is_f4;
  logic              known;
  logic [1:0]        op2;
  logic [3:0]        op4;
  logic [IW-1:0]     src_idx;
  logic [IW-1:0]     sec_idx;
  logic [IW-1:0]     dst_idx;
  logic [DW-1:0]     src_val;
  logic [DW-1:0]     sec_val;
  logic [DW-1:0]     dst_val;
  logic [DW-1:0]     small_imm;
  logic [DW-1:0]     byte_imm;
  logic [4:0]        shift_imm;
  logic              is_regsh;
  logic              is_mul;
  logic [2:0]        mul_cyc;
  logic [2:0]        need_cyc;
  logic              commit;

  logic [DW-1:0]     add_a;
  logic [DW-1:0]     add_b;
  logic              add_cin;
  logic [DW:0]       sum;
  logic              add_ovf;
  logic [DW-1:0]     prod;

  logic [DW-1:0]     sh_val;
  logic [cia_pkg::SH_AMT_W-1:0] sh_amt;
  logic [1:0]        sh_kind;
  logic [DW-1:0]     sh_res;
  logic              sh_c;

  logic [DW-1:0]     res;
  logic              wr_req;
  logic              next_c;
  logic              next_v;

  // Instruction in flight: a multi-cycle one is held so the decode stage may move on.
  assign cur    = (state == cia_pkg::CIA_HOLD) ? held : instr;
  assign accept = instr_valid && (state == cia_pkg::CIA_IDLE);

  // Formats are recognised by their fixed leading bits.
  assign is_f1 = (cur[cia_pkg::F13_TAG_HI:cia_pkg::F13_TAG_LO] == cia_pkg::F1_TAG)
               && (cur[cia_pkg::OP2_HI:cia_pkg::OP2_LO] != cia_pkg::SH_ROT);
  assign is_f2 = (cur[cia_pkg::F13_TAG_HI:cia_pkg::F2_TAG_LO] == cia_pkg::F2_TAG);
  assign is_f3 = (cur[cia_pkg::F13_TAG_HI:cia_pkg::F13_TAG_LO] == cia_pkg::F3_TAG);
  assign is_f4 = (cur[cia_pkg::F13_TAG_HI:cia_pkg::F4_TAG_LO] == cia_pkg::F4_TAG);
  assign known = is_f1 || is_f2 || is_f3 || is_f4;

  assign op2       = cur[cia_pkg::OP2_HI:cia_pkg::OP2_LO];
  assign op4       = cur[cia_pkg::OP4_HI:cia_pkg::OP4_LO];
  assign shift_imm = cur[cia_pkg::SHIMM_HI:cia_pkg::SHIMM_LO];
  // Three-bit fields can only name registers 0 to 7.
  assign src_idx = cur[cia_pkg::SRC_HI:cia_pkg::SRC_LO];
  assign sec_idx = cur[cia_pkg::SEC_HI:cia_pkg::SEC_LO];
  assign dst_idx = is_f3 ? cur[cia_pkg::F3_DST_HI:cia_pkg::F3_DST_LO]
                         : cur[cia_pkg::DST_HI:cia_pkg::DST_LO];
  assign src_val = regs[src_idx];
  assign sec_val = regs[sec_idx];
  assign dst_val = regs[dst_idx];
  assign small_imm = DW'(cur[cia_pkg::SEC_HI:cia_pkg::SEC_LO]);
  assign byte_imm  = DW'(cur[cia_pkg::BYTE_HI:cia_pkg::BYTE_LO]);

  // Timing: register-amount shifts cost one internal cycle, a product one
  // to four more depending on how many top bytes of the multiplier are sign.
  assign is_regsh = is_f4 && ((op4 == cia_pkg::OP4_SLL) || (op4 == cia_pkg::OP4_SRL)
                   || (op4 == cia_pkg::OP4_SRA) || (op4 == cia_pkg::OP4_ROT));
  assign is_mul   = is_f4 && (op4 == cia_pkg::OP4_MUL);
  assign mul_cyc  = ((dst_val[DW-1:cia_pkg::MUL_B1] == '0) || (&dst_val[DW-1:cia_pkg::MUL_B1]))
                    ? cia_pkg::CYC_MUL_M1 :
                    ((dst_val[DW-1:cia_pkg::MUL_B2] == '0) || (&dst_val[DW-1:cia_pkg::MUL_B2]))
                    ? cia_pkg::CYC_MUL_M2 :
                    ((dst_val[DW-1:cia_pkg::MUL_B3] == '0) || (&dst_val[DW-1:cia_pkg::MUL_B3]))
                    ? cia_pkg::CYC_MUL_M3 : cia_pkg::CYC_MUL_M4;
  assign need_cyc = is_mul ? mul_cyc : is_regsh ? cia_pkg::CYC_REGSH : cia_pkg::CYC_ONE;
  assign commit   = (accept && (need_cyc == cia_pkg::CYC_ONE))
                 || ((state == cia_pkg::CIA_HOLD) && (cnt == cia_pkg::CYC_ONE));

  // Adder operand selection; subtraction is addition of the inverse plus one.
  always_comb begin
    add_a   = dst_val;
    add_b   = ~src_val;
    add_cin = 1'b1;
    if (is_f2) begin
      add_a   = src_val;
      add_b   = cur[cia_pkg::F2_IMM_BIT] ? small_imm : sec_val;
      add_cin = cur[cia_pkg::F2_SUB_BIT];
      if (cur[cia_pkg::F2_SUB_BIT]) begin
        add_b = ~add_b;
      end
    end else if (is_f3) begin
      add_b   = (op2 == cia_pkg::OP3_ADD) ? byte_imm : ~byte_imm;
      add_cin = (op2 != cia_pkg::OP3_ADD);
    end else if (is_f4) begin
      case (op4)
        cia_pkg::OP4_ADC: begin
          add_b   = src_val;
          add_cin = flag_c;
        end
        cia_pkg::OP4_SBB: begin
          add_cin = flag_c;
        end
        cia_pkg::OP4_NEG: begin
          add_a = '0;
        end
        cia_pkg::OP4_ADF: begin
          add_b   = src_val;
          add_cin = 1'b0;
        end
        default: begin
          add_a = dst_val;
        end
      endcase
    end
  end

  assign sum     = {1'b0, add_a} + {1'b0, add_b} + {{DW{1'b0}}, add_cin};
  assign add_ovf = (add_a[DW-1] == add_b[DW-1]) && (sum[DW-1] != add_a[DW-1]);
  assign prod    = src_val * dst_val;

  // Shifted-move takes its amount from the instruction, the ALU form from the
  // low byte of the source register.
  assign sh_val  = is_f1 ? src_val : dst_val;
  assign sh_amt  = is_f1 ? cia_pkg::SH_AMT_W'(shift_imm) : src_val[cia_pkg::SH_AMT_W-1:0];
  assign sh_kind = is_f1 ? op2 :
                   (op4 == cia_pkg::OP4_SLL) ? cia_pkg::SH_LEFT :
                   (op4 == cia_pkg::OP4_SRL) ? cia_pkg::SH_RLOG :
                   (op4 == cia_pkg::OP4_SRA) ? cia_pkg::SH_RARITH : cia_pkg::SH_ROT;

  cia_shifter #(
    .DW (DW)
  ) u_shifter (
    .value    (sh_val),
    .amt      (sh_amt),
    .kind     (sh_kind),
    .imm_form (is_f1),
    .c_in     (flag_c),
    .result   (sh_res),
    .c_out    (sh_c)
  );

  // Result, write request and new carry/overflow.
  always_comb begin
    res    = sum[DW-1:0];
    wr_req = known;
    next_c = flag_c;
    next_v = flag_v;
    if (is_f1) begin
      res    = sh_res;
      next_c = sh_c;
    end else if (is_f2) begin
      next_c = sum[DW];
      next_v = add_ovf;
    end else if (is_f3) begin
      if (op2 == cia_pkg::OP3_COPY) begin
        res = byte_imm;
      end else begin
        next_c = sum[DW];
        next_v = add_ovf;
      end
      wr_req = (op2 != cia_pkg::OP3_CMP);
    end else if (is_f4) begin
      case (op4)
        cia_pkg::OP4_AND,
        cia_pkg::OP4_ANF: res = dst_val & src_val;
        cia_pkg::OP4_XOR: res = dst_val ^ src_val;
        cia_pkg::OP4_OR:  res = dst_val | src_val;
        cia_pkg::OP4_CLR: res = dst_val & ~src_val;
        cia_pkg::OP4_INV: res = ~src_val;
        cia_pkg::OP4_MUL: res = prod;
        cia_pkg::OP4_SLL,
        cia_pkg::OP4_SRL,
        cia_pkg::OP4_SRA,
        cia_pkg::OP4_ROT: begin
          res    = sh_res;
          next_c = sh_c;
        end
        default: begin
          next_c = sum[DW];
          next_v = add_ovf;
        end
      endcase
      wr_req = (op4 != cia_pkg::OP4_ANF) && (op4 != cia_pkg::OP4_CMP)
            && (op4 != cia_pkg::OP4_ADF);
    end
  end

  // Sequencer: single-cycle work commits on the accepting edge.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= cia_pkg::CIA_IDLE;
      cnt   <= '0;
      held  <= '0;
    end else begin
      case (state)
        cia_pkg::CIA_IDLE: begin
          if (accept && (need_cyc != cia_pkg::CYC_ONE)) begin
            state <= cia_pkg::CIA_HOLD;
            held  <= instr;
            cnt   <= need_cyc - cia_pkg::CYC_ONE;
          end
        end
        cia_pkg::CIA_HOLD: begin
          cnt <= cnt - cia_pkg::CYC_ONE;
          if (cnt == cia_pkg::CYC_ONE) begin
            state <= cia_pkg::CIA_IDLE;
          end
        end
        default: state <= cia_pkg::CIA_IDLE;
      endcase
    end
  end

  // The register bank holds only the low registers.
  for (genvar g = 0; g < NREG; g++) begin : g_bank
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        regs[g] <= '0;
      end else if (commit && wr_req && (dst_idx == IW'(g))) begin
        regs[g] <= res;
      end
    end
  end

  // Outputs and flags. An unknown encoding is reported and changes nothing.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {flag_n, flag_z, flag_c, flag_v} <= cia_pkg::FLAGS_RST;
      done      <= 1'b0;
      not_ours  <= 1'b0;
      wr_en     <= 1'b0;
      wr_idx    <= '0;
      wr_data   <= '0;
      busy      <= 1'b0;
      peek_data <= '0;
    end else begin
      done      <= commit && known;
      not_ours  <= commit && !known;
      wr_en     <= commit && wr_req;
      busy      <= (accept && (need_cyc != cia_pkg::CYC_ONE))
                || ((state == cia_pkg::CIA_HOLD) && (cnt != cia_pkg::CYC_ONE));
      peek_data <= regs[peek_idx];
      if (commit && known) begin
        wr_idx  <= dst_idx;
        wr_data <= res;
        flag_n  <= res[DW-1];
        flag_z  <= (res == '0);
        flag_c  <= next_c;
        flag_v  <= next_v;
      end
    end
  end

  // The busy output is a copy of the sequencer state, so the decode stage
  // sees the stall in the same cycle the sequencer enforces it.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_hold_two;
    busy ##1 !busy && done;
  endsequence

  a_copy_byte_value: assert property (
    accept && is_f3 && (op2 == cia_pkg::OP3_COPY)
    |=> wr_en && done && (wr_data == $past(byte_imm)) && (wr_idx == $past(dst_idx)))
    else $error("byte copy wrote a wrong value");

  a_compare_no_write: assert property (
    accept && is_f3 && (op2 == cia_pkg::OP3_CMP)
    |=> done && !wr_en && (flag_z == ($past(dst_val) == $past(byte_imm))))
    else $error("immediate compare wrote a register or bad zero flag");

  a_test_no_write: assert property (
    accept && is_f4 && ((op4 == cia_pkg::OP4_ANF) || (op4 == cia_pkg::OP4_ADF))
    |=> done && !wr_en)
    else $error("flag-only operation wrote a register");

  a_left_imm_shift: assert property (
    accept && is_f1 && (op2 == cia_pkg::SH_LEFT)
    |=> wr_en && (wr_data == ($past(src_val) << $past(shift_imm))))
    else $error("immediate left shift result wrong");

  a_shift_keeps_v: assert property (
    accept && is_f1 ##1 done |-> $stable(flag_v))
    else $error("shift changed the overflow flag");

  a_zero_flag_res: assert property (
    done |-> (flag_z == (wr_data == '0)) && (flag_n == wr_data[DW-1]))
    else $error("zero or negative flag does not follow the result");

  a_regsh_timing: assert property (
    accept && is_regsh |=> s_hold_two)
    else $error("register shift did not take two cycles");

  a_mul_timing: assert property (
    accept && is_mul |=> busy ##[1:4] done)
    else $error("product did not finish within native cycle bound");

  a_negate_value: assert property (
    accept && is_f4 && (op4 == cia_pkg::OP4_NEG)
    |=> wr_en && (wr_data == DW'(-$past(src_val))))
    else $error("two's complement result wrong");

  a_sub_reg_value: assert property (
    accept && is_f2 && cur[cia_pkg::F2_SUB_BIT] && !cur[cia_pkg::F2_IMM_BIT]
    |=> wr_en && (wr_data == DW'($past(src_val) - $past(sec_val))))
    else $error("three-operand subtract result wrong");

endmodule
`default_nettype wire

// File: hw/cia_pkg.sv
// Package with encodings, field positions and timing counts of the compact ALU decoder.
`default_nettype none
package cia_pkg;
  // Format recognition tags on the leading opcode bits.
  localparam int           F13_TAG_HI = 15;
  localparam int           F13_TAG_LO = 13;
  localparam int           F2_TAG_LO  = 11;
  localparam int           F4_TAG_LO  = 10;
  localparam logic [2:0]   F1_TAG     = 3'h0;
  localparam logic [4:0]   F2_TAG     = 5'h03;
  localparam logic [2:0]   F3_TAG     = 3'h1;
  localparam logic [5:0]   F4_TAG     = 6'h10;
  // Field positions.
  localparam int           OP2_HI     = 12;
  localparam int           OP2_LO     = 11;
  localparam int           SHIMM_HI   = 10;
  localparam int           SHIMM_LO   = 6;
  localparam int           SRC_HI     = 5;
  localparam int           SRC_LO     = 3;
  localparam int           DST_HI     = 2;
  localparam int           DST_LO     = 0;
  localparam int           F2_IMM_BIT = 10;
  localparam int           F2_SUB_BIT = 9;
  localparam int           SEC_HI     = 8;
  localparam int           SEC_LO     = 6;
  localparam int           F3_DST_HI  = 10;
  localparam int           F3_DST_LO  = 8;
  localparam int           BYTE_HI    = 7;
  localparam int           BYTE_LO    = 0;
  localparam int           OP4_HI     = 9;
  localparam int           OP4_LO     = 6;
  // Shifter kinds; the shifted-move opcodes use the first three directly.
  localparam logic [1:0]   SH_LEFT    = 2'h0;
  localparam logic [1:0]   SH_RLOG    = 2'h1;
  localparam logic [1:0]   SH_RARITH  = 2'h2;
  localparam logic [1:0]   SH_ROT     = 2'h3;
  localparam int           SH_AMT_W   = 8;
  localparam logic [5:0]   SH_FULL    = 6'h20;
  localparam logic [5:0]   SH_OVER    = 6'h21;
  // Immediate-format opcodes.
  localparam logic [1:0]   OP3_COPY   = 2'h0;
  localparam logic [1:0]   OP3_CMP    = 2'h1;
  localparam logic [1:0]   OP3_ADD    = 2'h2;
  localparam logic [1:0]   OP3_SUB    = 2'h3;
  // Two-register ALU opcodes.
  localparam logic [3:0]   OP4_AND    = 4'h0;
  localparam logic [3:0]   OP4_XOR    = 4'h1;
  localparam logic [3:0]   OP4_SLL    = 4'h2;
  localparam logic [3:0]   OP4_SRL    = 4'h3;
  localparam logic [3:0]   OP4_SRA    = 4'h4;
  localparam logic [3:0]   OP4_ADC    = 4'h5;
  localparam logic [3:0]   OP4_SBB    = 4'h6;
  localparam logic [3:0]   OP4_ROT    = 4'h7;
  localparam logic [3:0]   OP4_ANF    = 4'h8;
  localparam logic [3:0]   OP4_NEG    = 4'h9;
  localparam logic [3:0]   OP4_CMP    = 4'ha;
  localparam logic [3:0]   OP4_ADF    = 4'hb;
  localparam logic [3:0]   OP4_OR     = 4'hc;
  localparam logic [3:0]   OP4_MUL    = 4'hd;
  localparam logic [3:0]   OP4_CLR    = 4'he;
  localparam logic [3:0]   OP4_INV    = 4'hf;
  // Cycle counts matching the native equivalents.
  localparam int           CNT_W      = 3;
  localparam logic [2:0]   CYC_ONE    = 3'h1;
  localparam logic [2:0]   CYC_REGSH  = 3'h2;
  localparam logic [2:0]   CYC_MUL_M1 = 3'h2;
  localparam logic [2:0]   CYC_MUL_M2 = 3'h3;
  localparam logic [2:0]   CYC_MUL_M3 = 3'h4;
  localparam logic [2:0]   CYC_MUL_M4 = 3'h5;
  localparam int           MUL_B1     = 8;
  localparam int           MUL_B2     = 16;
  localparam int           MUL_B3     = 24;
  localparam logic [3:0]   FLAGS_RST  = 4'h0;
  typedef enum logic {CIA_IDLE, CIA_HOLD} cia_state_type;
endpackage
`default_nettype wire

// File: hw/cia_shifter.sv
// Barrel shifter with native carry-out rules for immediate and register amounts.
`default_nettype none
module cia_shifter #(
  parameter int DW = 32
) (
  input  wire logic [DW-1:0]                value,
  input  wire logic [cia_pkg::SH_AMT_W-1:0] amt,
  input  wire logic [1:0]                   kind,
  input  wire logic                         imm_form,
  input  wire logic                         c_in,
  output logic      [DW-1:0]                result,
  output logic                              c_out
);
  localparam int RW = $clog2(DW);

  logic              zero_amt;
  logic              keep;
  logic              fill;
  logic [5:0]        eff;
  logic [2*DW:0]     left_ext;
  logic [2*DW+1:0]   right_ext;
  logic [2*DW-1:0]   rot_ext;

  assign zero_amt = (amt == '0);
  // An immediate of zero means a full-width shift for right shifts, so only
  // a left shift by zero, or any register amount of zero, keeps value and carry.
  assign keep = zero_amt && !(imm_form && (kind != cia_pkg::SH_LEFT));
  assign fill = (kind == cia_pkg::SH_RARITH) ? value[DW-1] : 1'b0;
  assign eff  = (imm_form && zero_amt) ? cia_pkg::SH_FULL :
                (amt > 8'(cia_pkg::SH_OVER)) ? cia_pkg::SH_OVER : amt[5:0];
  assign left_ext  = {{(DW+1){1'b0}}, value} << eff;
  assign right_ext = {{(DW+1){fill}}, value, 1'b0} >> eff;
  assign rot_ext   = {value, value} >> amt[RW-1:0];

  always_comb begin
    result = value;
    c_out  = c_in;
    if (!keep) begin
      case (kind)
        cia_pkg::SH_LEFT: begin
          result = left_ext[DW-1:0];
          c_out  = left_ext[DW];
        end
        cia_pkg::SH_ROT: begin
          result = rot_ext[DW-1:0];
          c_out  = rot_ext[DW-1];
        end
        default: begin
          result = right_ext[DW:1];
          c_out  = right_ext[0];
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tb/cia_issue_model.sv
// Instruction source model that holds each word until the decoder takes it.
`default_nettype none
module cia_issue_model (
  input  wire logic        mclk,
  input  wire logic        busy,
  output var  logic        instr_valid,
  output var  logic [15:0] instr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] q[$];
  logic        t;
  function automatic void push(input logic [15:0] w);
    q.push_back(w);
  endfunction
  // A released word shows its inverse, so a late sample cannot match by luck.
  initial begin
    instr_valid = 1'h0;
    instr       = 16'h0000;
    forever begin
      @(posedge mclk);
      t = instr_valid && !busy;
      #1;
      if ((t || !instr_valid) && q.size() > 0) begin
        instr_valid = 1'h1;
        instr       = q.pop_front();
      end else if (t) begin
        instr_valid = 1'h0;
        instr       = ~instr;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/cia_testbench.sv
// Self-checking bench for the compact ALU decoder.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rst, instr_valid, busy, done, not_ours, wr_en, e_wr, e_ours;
  logic        flag_n, flag_z, flag_c, flag_v;
  logic [15:0] instr;
  logic [2:0]  peek_idx, wr_idx, e_idx;
  logic [31:0] wr_data, peek_data, e_res;
  logic [31:0] sreg[8];
  logic [3:0]  sf;
  int          e_cyc, fails, checked;
  cia_alu_ops_decode cia_alu_ops_decode_i (.mclk, .rst, .instr_valid, .instr, .peek_idx,
    .busy, .done, .not_ours, .wr_en, .wr_idx, .wr_data, .flag_n, .flag_z, .flag_c,
    .flag_v, .peek_data);
  cia_issue_model cia_issue_model_i (.mclk, .busy, .instr_valid, .instr);
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [15:0] f1(input logic [1:0] o, input logic [4:0] n,
                                     input logic [2:0] s, input logic [2:0] d);
    return {3'h0, o, n, s, d};
  endfunction
  function automatic logic [15:0] f3(input logic [1:0] o, input logic [2:0] d,
                                     input logic [7:0] n);
    return {3'h1, o, d, n};
  endfunction
  function automatic logic [15:0] f4(input logic [3:0] o, input logic [2:0] s,
                                     input logic [2:0] d);
    return {6'h10, o, s, d};
  endfunction
  task automatic cmp(input string s, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic add(input logic [31:0] a, input logic [31:0] b, input logic ci,
                     output logic [31:0] r, output logic c, output logic v);
    {c, r} = {1'h0, a} + {1'h0, b} + {32'h0, ci};
    v = a[31] == b[31] && r[31] != a[31];
  endtask
  task automatic shf(input logic [1:0] k, input logic [31:0] x, input logic [7:0] n,
                     input logic im, input logic ci, output logic [31:0] r, output logic c);
    logic [63:0] y;
    r = x;
    c = ci;
    if (im && k != 2'h0 && n == 8'h00) n = 8'h20;
    if (k == 2'h3 && n != 8'h00) begin
      y = {x, x} >> n[4:0];
      r = y[31:0];
      c = r[31];
    end else if (k == 2'h2 && n != 8'h00) begin
      y = $signed({x, 32'h0}) >>> (n > 8'h20 ? 8'h20 : n);
      r = y[63:32];
      c = y[31];
    end else if (n > 8'h20) begin
      r = 32'h0;
      c = 1'h0;
    end else if (k == 2'h0 && n != 8'h00) begin
      y = {32'h0, x} << n;
      r = y[31:0];
      c = y[32];
    end else if (n != 8'h00) begin
      y = {x, 32'h0} >> n;
      r = y[63:32];
      c = y[31];
    end
  endtask
  task automatic ref_step(input logic [15:0] w);
    logic [31:0] a, b, r;
    logic [3:0]  op;
    logic        c, v;
    c = sf[1];
    v = sf[0];
    e_idx = w[2:0];
    a = sreg[w[5:3]];
    b = sreg[w[8:6]];
    op = w[9:6];
    r = a;
    e_cyc = 1;
    e_wr = 1'h1;
    e_ours = 1'h1;
    if (w[15:11] == 5'h03) begin
      if (w[10]) b = {29'h0, w[8:6]};
      add(a, w[9] ? ~b : b, w[9], r, c, v);
    end else if (w[15:13] == 3'h0) begin
      shf(w[12:11], a, {3'h0, w[10:6]}, 1'h1, c, r, c);
    end else if (w[15:13] == 3'h1) begin
      e_idx = w[10:8];
      b = {24'h0, w[7:0]};
      e_wr = w[12:11] != 2'h1;
      if (w[12:11] == 2'h0) r = b;
      else add(sreg[e_idx], w[11] ? ~b : b, w[11], r, c, v);
    end else if (w[15:10] == 6'h10) begin
      b = a;
      a = sreg[e_idx];
      e_wr = !(op inside {4'h8, 4'ha, 4'hb});
      case (op)
        4'h0, 4'h8: r = a & b;
        4'h1: r = a ^ b;
        4'hc: r = a | b;
        4'he: r = a & ~b;
        4'hf: r = ~b;
        4'h5: add(a, b, sf[1], r, c, v);
        4'h6: add(a, ~b, sf[1], r, c, v);
        4'h9: add(32'h0, ~b, 1'h1, r, c, v);
        4'ha: add(a, ~b, 1'h1, r, c, v);
        4'hb: add(a, b, 1'h0, r, c, v);
        4'hd: begin
          r = a * b;
          e_cyc = (a[31:8] == 24'h0 || &a[31:8]) ? 2 : (a[31:16] == 16'h0 || &a[31:16]) ? 3 :
                  (a[31:24] == 8'h0 || &a[31:24]) ? 4 : 5;
        end
        default: begin
          e_cyc = 2;
          shf(op == 4'h7 ? 2'h3 : 2'(op - 4'h2), a, b[7:0], 1'h0, c, r, c);
        end
      endcase
    end else begin
      e_ours = 1'h0;
      e_wr = 1'h0;
    end
    e_res = r;
    if (e_ours) sf = {r[31], r == 32'h0, c, v};
    if (e_wr) sreg[e_idx] = r;
  endtask
  // Words are queued at once, so single-cycle ones issue back to back.
  task automatic exec(input logic [15:0] ws[$]);
    int tq[$];
    int e, k;
    e = 0;
    k = 0;
    foreach (ws[i]) cia_issue_model_i.push(ws[i]);
    while (k < ws.size() && e < 300) begin
      @(posedge mclk);
      if (instr_valid === 1'h1 && busy === 1'h0) tq.push_back(e);
      e++;
      #3;
      if (done === 1'h1 || not_ours === 1'h1) begin
        ref_step(ws[k]);
        k++;
        cmp("cycles", e_cyc, e - tq.pop_front());
        cmp("done", e_ours, done);
        cmp("not_ours", !e_ours, not_ours);
        cmp("wr_en", e_wr, wr_en);
        cmp("flags", sf, {flag_n, flag_z, flag_c, flag_v});
        if (e_ours) cmp("wr_idx", e_idx, wr_idx);
        if (e_ours) cmp("wr_data", e_res, wr_data);
      end
    end
    if (k < ws.size()) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic check_regs();
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      #1 peek_idx = 3'(i);
      @(posedge mclk);
      #3 cmp("peek_data", sreg[i], peek_data);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_alu(input logic [2:0] s, input logic [7:0] n);
    logic [15:0] ws[$];
    ws.push_back(f3(2'h0, s, n));
    for (int o = 0; o < 16; o++) ws.push_back(f4(4'(o), s, 3'(o)));
    exec(ws);
    $display("[DONE] alu ops from r%0d", s);
  endtask
  task automatic t_reset();
    cmp("reset_flags", 4'h0, {flag_n, flag_z, flag_c, flag_v});
    check_regs();
    $display("[DONE] reset state");
  endtask
  task automatic t_formats();
    exec('{f3(2'h0, 3'h0, 8'h80), f3(2'h0, 3'h1, 8'hff), f3(2'h2, 3'h1, 8'hff),
           f3(2'h1, 3'h2, 8'h3e), f3(2'h3, 3'h6, 8'h91),
           f3(2'h1, 3'h0, 8'h80)});
    exec('{f1(2'h0, 5'h18, 3'h0, 3'h3), f1(2'h1, 5'h1b, 3'h3, 3'h2), f1(2'h2, 5'h00, 3'h3, 3'h4),
           f1(2'h0, 5'h00, 3'h3, 3'h5), f1(2'h1, 5'h00, 3'h1, 3'h6),
           f1(2'h2, 5'h01, 3'h3, 3'h7)});
    exec('{16'h1900, 16'h1de1, 16'h1ad5, 16'h1f96});
    $display("[DONE] shift, add and immediate formats");
  endtask
  task automatic t_product();
    exec('{f3(2'h0, 3'h5, 8'h40), f4(4'hd, 3'h5, 3'h5), f4(4'hd, 3'h5, 3'h5),
           f4(4'hd, 3'h5, 3'h5), f3(2'h0, 3'h6, 8'h01), f1(2'h0, 5'h10, 3'h6, 3'h6),
           f4(4'hd, 3'h6, 3'h6), f4(4'hf, 3'h0, 3'h4), f4(4'hd, 3'h4, 3'h4)});
    $display("[DONE] product timing");
  endtask
  task automatic t_foreign();
    exec('{16'h4400, 16'he000, f3(2'h0, 3'h0, 8'h05)});
    check_regs();
    $display("[DONE] foreign words and register file");
  endtask
  initial begin
    fails = 0;
    checked = 0;
    rst = 1'h1;
    peek_idx = 3'h0;
    sf = 4'h0;
    foreach (sreg[i]) sreg[i] = 32'h0;
    repeat (3) @(posedge mclk);
    #1 rst = 1'h0;
    t_reset();
    t_formats();
    t_alu(3'h2, 8'h10);
    t_alu(3'h1, 8'h21);
    t_product();
    t_foreign();
    tally_and_finish();
  end
endmodule
`default_nettype wire
